// File: hdl/twrba_regs.svh
// byte addresses, widths and reset values of the timer's wide-register window
`ifndef TWRBA_REGS_SVH
`define TWRBA_REGS_SVH
`define TWRBA_ADDR_CNT_LO 3'h0
`define TWRBA_ADDR_CNT_HI 3'h1
`define TWRBA_ADDR_CMPA_LO 3'h2
`define TWRBA_ADDR_CMPA_HI 3'h3
`define TWRBA_ADDR_CMPB_LO 3'h4
`define TWRBA_ADDR_CMPB_HI 3'h5
`define TWRBA_ADDR_CAP_LO 3'h6
`define TWRBA_ADDR_CAP_HI 3'h7
`define TWRBA_HOLD_RST 8'h00
`define TWRBA_WIDE_RST 16'h0000
`endif

// File: hdl/twrba_pkg.sv
// types shared by both ends of the wide-register byte access link
package twrba_pkg;
   typedef logic [2:0] twrba_addr_type;
   typedef logic [7:0] twrba_byte_type;
   typedef logic [15:0] twrba_word_type;
   typedef enum logic [1:0] {TWRBA_CNT, TWRBA_CMPA, TWRBA_CMPB, TWRBA_CAP} twrba_sel_type;
endpackage : twrba_pkg

// File: hdl/twrba_if.sv
// byte bus between the processor end and the timer's register end
interface twrba_if;
   import twrba_pkg::*;
   logic wr_en;
   logic rd_en;
   twrba_addr_type addr;
   twrba_byte_type wdata;
   twrba_byte_type rdata;
   modport timer (input wr_en, input rd_en, input addr, input wdata, output rdata);
   modport cpu (output wr_en, output rd_en, output addr, output wdata, input rdata);
endinterface : twrba_if

// File: hdl/twrba_timer.sv
// timer end: wide registers reached through one shared high-byte holding register
`include "twrba_regs.svh"
// Behaviour
// [R1] wide registers reached as two byte accesses
// [R2] one eight-bit holding register per timer
// [R3] holding register shared by all wide registers
// [R4] only low-byte access moves the wide word
// [R5] low write loads holding and byte together
// [R6] low read copies high half to holding
// [R7] compare reads bypass the holding register
// [R8] processor writes high byte before low byte
// [R9] processor reads low byte before high byte
// [R10] processor keeps interrupts off holding register
// [R11] high write updates holding; high read returns it
module twrba_timer
   import twrba_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   twrba_if.timer BUS,
   input wire logic CNT_LOAD,
   input wire logic [15:0] CNT_NEXT,
   input wire logic CAP_LOAD,
   input wire logic [15:0] CAP_NEXT,
   output logic [15:0] CNT_VALUE,
   output logic [15:0] CMPA_VALUE,
   output logic [15:0] CMPB_VALUE,
   output logic [15:0] CAP_VALUE,
   output logic CNT_WRITTEN
);
   twrba_byte_type hold_ff;
   twrba_word_type cnt_ff;
   twrba_word_type cmpa_ff;
   twrba_word_type cmpb_ff;
   twrba_word_type cap_ff;
   twrba_byte_type rdata_ff;
   logic cnt_wr_ff;
   logic lo_acc;
   twrba_sel_type sel;
   twrba_word_type sel_word;

   // [R1] address bit 0 picks the byte
   assign lo_acc = (BUS.addr[0] == 1'b0);
   assign sel = twrba_sel_type'(BUS.addr[2:1]);

   always_comb begin
      unique case (sel)
         TWRBA_CNT: sel_word = cnt_ff;
         TWRBA_CMPA: sel_word = cmpa_ff;
         TWRBA_CMPB: sel_word = cmpb_ff;
         TWRBA_CAP: sel_word = cap_ff;
      endcase
   end

   // [R2] single holding byte
   // [R3] shared across every wide register
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         hold_ff <= `TWRBA_HOLD_RST;
      end else if (BUS.wr_en && !lo_acc) begin
         // [R11] high write only updates holding
         hold_ff <= BUS.wdata;
      end else if (BUS.rd_en && lo_acc && sel != TWRBA_CMPA && sel != TWRBA_CMPB) begin
         // [R6] latch high half on low read
         // [R7] compare reads leave holding alone
         hold_ff <= sel_word[15:8];
      end
   end

   // [R4] wide write only on low byte
   // [R5] holding plus written byte, one cycle
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         cnt_ff <= `TWRBA_WIDE_RST;
         cmpa_ff <= `TWRBA_WIDE_RST;
         cmpb_ff <= `TWRBA_WIDE_RST;
         cap_ff <= `TWRBA_WIDE_RST;
         cnt_wr_ff <= 1'b0;
      end else begin
         cnt_wr_ff <= BUS.wr_en && lo_acc && sel == TWRBA_CNT;
         // processor write wins over the count update in the same cycle
         if (BUS.wr_en && lo_acc && sel == TWRBA_CNT) begin
            cnt_ff <= {hold_ff, BUS.wdata};
         end else if (CNT_LOAD) begin
            cnt_ff <= CNT_NEXT;
         end
         if (BUS.wr_en && lo_acc && sel == TWRBA_CMPA) begin
            cmpa_ff <= {hold_ff, BUS.wdata};
         end
         if (BUS.wr_en && lo_acc && sel == TWRBA_CMPB) begin
            cmpb_ff <= {hold_ff, BUS.wdata};
         end
         if (BUS.wr_en && lo_acc && sel == TWRBA_CAP) begin
            cap_ff <= {hold_ff, BUS.wdata};
         end else if (CAP_LOAD) begin
            cap_ff <= CAP_NEXT;
         end
      end
   end

   // read data registered: available the cycle after rd_en
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         rdata_ff <= 8'h00;
      end else if (BUS.rd_en) begin
         if (lo_acc) begin
            rdata_ff <= sel_word[7:0];
         end else if (sel == TWRBA_CMPA || sel == TWRBA_CMPB) begin
            // [R7] compare high byte straight from register
            rdata_ff <= sel_word[15:8];
         end else begin
            // [R11] high read returns holding
            rdata_ff <= hold_ff;
         end
      end
   end

   assign BUS.rdata = rdata_ff;
   assign CNT_VALUE = cnt_ff;
   assign CMPA_VALUE = cmpa_ff;
   assign CMPB_VALUE = cmpb_ff;
   assign CAP_VALUE = cap_ff;
   assign CNT_WRITTEN = cnt_wr_ff;
endmodule : twrba_timer

// File: hdl/twrba_cpu.sv
// processor end: splits wide reads and writes into correctly ordered byte accesses
`include "twrba_regs.svh"
module twrba_cpu
   import twrba_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   twrba_if.cpu BUS,
   input wire logic REQ_VALID,
   input wire logic REQ_WRITE,
   input wire logic [1:0] REQ_SEL,
   input wire logic [15:0] REQ_WDATA,
   output logic REQ_READY,
   output logic RSP_VALID,
   output logic [15:0] RSP_RDATA
);
   typedef enum logic [2:0] {ST_IDLE, ST_WR_LO, ST_RD_HI, ST_RD_WAIT, ST_RD_DONE} twrba_st_type;
   twrba_st_type st_ff;
   logic [1:0] sel_ff;
   twrba_word_type data_ff;
   logic rsp_ff;

   // [R10] one transfer at a time
   // one transfer at a time keeps the shared holding byte private (interrupt safety)
   assign REQ_READY = (st_ff == ST_IDLE);

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         st_ff <= ST_IDLE;
         sel_ff <= 2'h0;
         data_ff <= 16'h0000;
         rsp_ff <= 1'b0;
      end else begin
         rsp_ff <= 1'b0;
         unique case (st_ff)
            ST_IDLE: begin
               if (REQ_VALID) begin
                  sel_ff <= REQ_SEL;
                  data_ff <= REQ_WDATA;
                  // [R8] high byte goes out first
                  // [R9] low byte read first
                  st_ff <= REQ_WRITE ? ST_WR_LO : ST_RD_HI;
               end
            end
            ST_WR_LO: st_ff <= ST_IDLE;
            ST_RD_HI: begin
               // low byte stands on rdata while the high read is issued
               data_ff[7:0] <= BUS.rdata;
               st_ff <= ST_RD_WAIT;
            end
            ST_RD_WAIT: begin
               data_ff[15:8] <= BUS.rdata;
               st_ff <= ST_RD_DONE;
            end
            ST_RD_DONE: begin
               rsp_ff <= 1'b1;
               st_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // [R1] each access is one byte
   always_comb begin
      BUS.wr_en = 1'b0;
      BUS.rd_en = 1'b0;
      BUS.addr = {REQ_SEL, 1'b1};
      BUS.wdata = REQ_WDATA[15:8];
      unique case (st_ff)
         ST_IDLE: begin
            BUS.wr_en = REQ_VALID && REQ_WRITE;
            BUS.rd_en = REQ_VALID && !REQ_WRITE;
            BUS.addr = {REQ_SEL, REQ_WRITE};
            BUS.wdata = REQ_WDATA[15:8];
         end
         ST_WR_LO: begin
            BUS.wr_en = 1'b1;
            BUS.addr = {sel_ff, 1'b0};
            BUS.wdata = data_ff[7:0];
         end
         ST_RD_HI: begin
            BUS.rd_en = 1'b1;
            BUS.addr = {sel_ff, 1'b1};
            BUS.wdata = 8'h00;
         end
         ST_RD_WAIT, ST_RD_DONE: begin
            BUS.addr = {sel_ff, 1'b1};
            BUS.wdata = 8'h00;
         end
      endcase
   end

   assign RSP_VALID = rsp_ff;
   assign RSP_RDATA = data_ff;
endmodule : twrba_cpu

// File: test/twrba_chk.sv
// byte bus checker between the processor end and the timer end
module twrba_chk
   import twrba_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire twrba_addr_type addr,
   input wire twrba_byte_type wdata,
   input wire twrba_byte_type rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   sequence wr_pair_s;
      wr_en && addr[0] ##1 wr_en && !addr[0] && addr[2:1] == $past(addr[2:1]);
   endsequence
   sequence rd_pair_s;
      rd_en && !addr[0] ##1 rd_en && addr[0] && addr[2:1] == $past(addr[2:1]);
   endsequence
   one_strobe_a: assert property (!(wr_en && rd_en)) else $error("both strobes high");
   write_pair_a: assert property (wr_en && addr[0] |-> wr_pair_s) else $error("high write unpaired");
   low_write_a: assert property (wr_en && !addr[0] |-> $past(wr_en) && $past(addr[0]))
      else $error("low write without high write");
   read_pair_a: assert property (rd_en && !addr[0] |-> rd_pair_s) else $error("low read unpaired");
   high_read_a: assert property (rd_en && addr[0] |-> $past(rd_en) && !$past(addr[0]))
      else $error("high read without low read");
   rdata_hold_a: assert property (!rd_en |=> $stable(rdata)) else $error("read byte moved");
   rdata_cause_a: assert property ($changed(rdata) |-> $past(rd_en)) else $error("read byte unprompted");
   reset_rdata_a: assert property ($fell(RST) |-> rdata == 8'h00) else $error("read byte not cleared");
endmodule : twrba_chk

// File: test/tb.sv
// bench: wide writes, reads and hardware loads through both ends
module tb;
   import twrba_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLOCK = 1'b0;
   logic RST = 1'b1;
   logic REQ_VALID = 1'b0;
   logic REQ_WRITE = 1'b0;
   logic [1:0] REQ_SEL = 2'h0;
   logic [15:0] REQ_WDATA = 16'h0000;
   logic CNT_LOAD = 1'b0;
   logic CAP_LOAD = 1'b0;
   logic [15:0] CNT_NEXT = 16'h0000;
   logic [15:0] CAP_NEXT = 16'h0000;
   logic REQ_READY;
   logic RSP_VALID;
   logic [15:0] RSP_RDATA;
   logic [15:0] vals [4];
   logic [15:0] wv [4];
   logic [15:0] exp_q [$];
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   twrba_if bus ();
   twrba_timer twrba_timer_inst (.CLOCK(CLOCK), .RST(RST), .BUS(bus.timer), .CNT_LOAD(CNT_LOAD),
      .CNT_NEXT(CNT_NEXT), .CAP_LOAD(CAP_LOAD), .CAP_NEXT(CAP_NEXT), .CNT_VALUE(vals[0]),
      .CMPA_VALUE(vals[1]), .CMPB_VALUE(vals[2]), .CAP_VALUE(vals[3]), .CNT_WRITTEN());
   twrba_cpu twrba_cpu_inst (.CLOCK(CLOCK), .RST(RST), .BUS(bus.cpu), .REQ_VALID(REQ_VALID),
      .REQ_WRITE(REQ_WRITE), .REQ_SEL(REQ_SEL), .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY),
      .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA));
   twrba_chk twrba_chk_inst (.CLOCK(CLOCK), .RST(RST), .wr_en(bus.wr_en), .rd_en(bus.rd_en),
      .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata));
   always #2 CLOCK = ~CLOCK;
   task check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task req(input logic w, input logic [1:0] s, input logic [15:0] v);
      @(negedge CLOCK);
      while (REQ_READY !== 1'b1) @(negedge CLOCK);
      REQ_VALID = 1'b1;
      REQ_WRITE = w;
      REQ_SEL = s;
      REQ_WDATA = v;
      if (!w) exp_q.push_back(v);
      @(negedge CLOCK);
      REQ_VALID = 1'b0;
      while (w && REQ_READY !== 1'b1) @(negedge CLOCK);
      if (w) check(vals[s], v);
   endtask : req
   always @(negedge CLOCK) begin
      if (RSP_VALID === 1'b1) check(RSP_RDATA, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
   end
   always @(posedge CLOCK) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         stop_test();
      end
   end
   initial begin
      void'($urandom(85));
      repeat (4) @(posedge CLOCK);
      @(negedge CLOCK) RST = 1'b0;
      for (int i = 0; i < 4; i++) begin
         wv[i] = 16'($urandom);
         req(1'b1, 2'(i), wv[i]);
      end
      $display("test writes done");
      // reverse order so compare reads follow a capture-register holding update
      for (int i = 3; i >= 0; i--) req(1'b0, 2'(i), wv[i]);
      req(1'b0, 2'h0, wv[0]);
      $display("test reads done");
      @(negedge CLOCK);
      CNT_LOAD = 1'b1;
      CAP_LOAD = 1'b1;
      CNT_NEXT = 16'($urandom);
      CAP_NEXT = 16'hff00;
      @(negedge CLOCK);
      CNT_LOAD = 1'b0;
      CAP_LOAD = 1'b0;
      check(vals[3], CAP_NEXT);
      req(1'b0, 2'h0, CNT_NEXT);
      req(1'b0, 2'h3, CAP_NEXT);
      req(1'b0, 2'h1, wv[1]);
      repeat (8) @(negedge CLOCK);
      $display("test loads done");
      stop_test();
   end
endmodule : tb
